// ---- core/sap_pkg.sv ----
// Constants shared by the storage address protection block.
// Assumes one CPU clock; all users of this package qualify names fully.
package sap_pkg;

  // Virtual address layout: 12-bit segment, 16-bit halfword offset
  localparam int VA_W           = 28;
  localparam int SEG_W          = 12;
  localparam int OFF_W          = 16;
  localparam int SEG_LSB        = 16;
  localparam int SEG_MAX_BYTES  = 131072;
  localparam int SEG_COUNT      = 4096;
  localparam int SEG_GROUP_SIZE = 1024;
  localparam int SEG_GROUP_W    = 2;
  localparam int SHARED_SEGS    = 2048;

  // Pages inside a segment and the physical side
  localparam int PAGE_W    = 6;
  localparam int PAGE_LSB  = 10;
  localparam int PPN_W     = 16;
  localparam int PA_W      = 26;
  localparam int USER_W    = 8;
  localparam int XB_DEPTH  = 8;
  localparam int XB_IDX_W  = 3;

  // Ring numbers
  localparam logic [1:0] RING_KERNEL = 2'h0;
  localparam logic [1:0] RING_MID    = 2'h1;
  localparam logic [1:0] RING_USER   = 2'h3;

  // Permission bit positions
  localparam int PERM_READ  = 0;
  localparam int PERM_WRITE = 1;
  localparam int PERM_EXEC  = 2;

  // Trap causes
  localparam logic [1:0] TRAP_NONE   = 2'h0;
  localparam logic [1:0] TRAP_MISS   = 2'h1;
  localparam logic [1:0] TRAP_ACCESS = 2'h2;
  localparam logic [1:0] TRAP_PAGE   = 2'h3;

  // Reset values
  localparam logic [VA_W-1:0] ADDR_RST = 28'h0000000;
  localparam logic [PA_W-1:0] PA_RST   = 26'h0000000;

  typedef enum logic [2:0] {
    REF_READ  = 3'h1,
    REF_WRITE = 3'h2,
    REF_FETCH = 3'h4
  } sap_ref_e;

  typedef enum logic [4:0] {
    SRC_PC       = 5'h01,
    SRC_OPERAND  = 5'h02,
    SRC_MICRO    = 5'h04,
    SRC_OPBACKUP = 5'h08,
    SRC_PCBACKUP = 5'h10
  } sap_src_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_CHECK = 2'h2
  } sap_state_e;

endpackage

// ---- core/sap_top.sv ----
// Storage address path and protection check for the storage management unit.
// Assumes pipeline, microcode and cache share sys_clk; request inputs are
// same-domain logic and are not synchronised.
`timescale 1ns/10ps
module sap_top (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Address sources
  input  wire logic [sap_pkg::VA_W-1:0]      pcAddr,
  input  wire logic [sap_pkg::VA_W-1:0]      operandAddr,
  input  wire logic [sap_pkg::VA_W-1:0]      microAddr,
  // Reference request
  input  wire logic                          refValid,
  input  wire logic [4:0]                    refSrc,
  input  wire logic [2:0]                    refType,
  input  wire logic [1:0]                    curRing,
  input  wire logic [sap_pkg::USER_W-1:0]    userId,
  // Translation fill from miss microcode
  input  wire logic                          fillValid,
  input  wire logic                          flushAll,
  input  wire logic [sap_pkg::SEG_W-1:0]     fillSeg,
  input  wire logic [sap_pkg::PAGE_W-1:0]    fillPage,
  input  wire logic [sap_pkg::USER_W-1:0]    fillUser,
  input  wire logic [sap_pkg::PPN_W-1:0]     fillPhysPage,
  input  wire logic                          fillResident,
  input  wire logic [2:0]                    fillUserPerm,
  input  wire logic [2:0]                    fillMidPerm,
  input  wire logic                          fillKernelSeg,
  input  wire logic                          fillGate,
  // Address registers
  output logic [sap_pkg::VA_W-1:0]           internalAddrBus,
  output logic [sap_pkg::VA_W-1:0]           cacheAddr,
  output logic [sap_pkg::VA_W-1:0]           xlateAddr,
  output logic [sap_pkg::VA_W-1:0]           workingMemAddr,
  output logic [sap_pkg::VA_W-1:0]           operandBackupAddr,
  output logic [sap_pkg::VA_W-1:0]           pcBackupAddr,
  // Check result
  output logic                               refDone,
  output logic                               refGranted,
  output logic                               memTrap,
  output logic [1:0]                         trapCause,
  output logic [sap_pkg::PA_W-1:0]           physAddr,
  output logic [sap_pkg::SEG_GROUP_W-1:0]    segGroup,
  output logic                               sharedSeg
);

  sap_pkg::sap_state_e              state_r;
  sap_pkg::sap_state_e              state_nxt;
  logic [sap_pkg::VA_W-1:0]         bus_r;
  logic [sap_pkg::VA_W-1:0]         busNext;
  logic [sap_pkg::VA_W-1:0]         cacheAddr_r;
  logic [sap_pkg::VA_W-1:0]         xlateAddr_r;
  logic [sap_pkg::VA_W-1:0]         workAddr_r;
  logic [sap_pkg::VA_W-1:0]         opBackup_r;
  logic [sap_pkg::VA_W-1:0]         pcBackup_r;
  logic [2:0]                       refType_r;
  logic [1:0]                       ring_r;
  logic [sap_pkg::USER_W-1:0]       user_r;
  logic                             done_r;
  logic                             granted_r;
  logic                             trap_r;
  logic [1:0]                       cause_r;
  logic [sap_pkg::PA_W-1:0]         phys_r;
  logic [sap_pkg::SEG_GROUP_W-1:0]  group_r;
  logic                             shared_r;
  logic                             srcOk;
  logic                             lkHit;
  logic [sap_pkg::PPN_W-1:0]        lkPhysPage;
  logic                             lkResident;
  logic [2:0]                       lkUserPerm;
  logic [2:0]                       lkMidPerm;
  logic                             lkKernelSeg;
  logic                             lkGate;
  logic                             needBit;
  logic                             allow;
  logic [sap_pkg::SEG_W-1:0]        curSeg;

  assign internalAddrBus   = bus_r;
  assign cacheAddr         = cacheAddr_r;
  assign xlateAddr         = xlateAddr_r;
  assign workingMemAddr    = workAddr_r;
  assign operandBackupAddr = opBackup_r;
  assign pcBackupAddr      = pcBackup_r;
  assign refDone           = done_r;
  assign refGranted        = granted_r;
  assign memTrap           = trap_r;
  assign trapCause         = cause_r;
  assign physAddr          = phys_r;
  assign segGroup          = group_r;
  assign sharedSeg         = shared_r;

  // Backups feed the bus so a miss or unaligned access can restore its address
  always_comb begin
    srcOk = 1'b1;
    unique case (refSrc)
      sap_pkg::SRC_PC:       busNext = pcAddr;
      sap_pkg::SRC_OPERAND:  busNext = operandAddr;
      sap_pkg::SRC_MICRO:    busNext = microAddr;
      sap_pkg::SRC_OPBACKUP: busNext = opBackup_r;
      sap_pkg::SRC_PCBACKUP: busNext = pcBackup_r;
      default: begin
        busNext = bus_r;
        srcOk   = 1'b0;
      end
    endcase
  end

  // Request taken only with a legal source; a bad select loads nothing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sap_pkg::ST_IDLE:  if (refValid && srcOk) state_nxt = sap_pkg::ST_CHECK;
      sap_pkg::ST_CHECK: if (!(refValid && srcOk)) state_nxt = sap_pkg::ST_IDLE;
      default:           state_nxt = sap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_r <= sap_pkg::ST_IDLE;
    else        state_r <= state_nxt;
  end

  // Every address register loads from the one bus value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r       <= sap_pkg::ADDR_RST;
      cacheAddr_r <= sap_pkg::ADDR_RST;
      xlateAddr_r <= sap_pkg::ADDR_RST;
      workAddr_r  <= sap_pkg::ADDR_RST;
    end else if (refValid && srcOk) begin
      bus_r       <= busNext;
      cacheAddr_r <= busNext;
      xlateAddr_r <= busNext;
      workAddr_r  <= busNext;
    end
  end

  // Backups copy what the working register receives in the same edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opBackup_r <= sap_pkg::ADDR_RST;
      pcBackup_r <= sap_pkg::ADDR_RST;
    end else if (refValid) begin
      if (refSrc == sap_pkg::SRC_OPERAND) opBackup_r <= busNext;
      if (refSrc == sap_pkg::SRC_PC)      pcBackup_r <= busNext;
    end
  end

  // Reference attributes held for the check beat
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refType_r <= sap_pkg::REF_READ;
      ring_r    <= sap_pkg::RING_USER;
      user_r    <= '0;
    end else if (refValid && srcOk) begin
      refType_r <= refType;
      // The unused ring code is treated as the least privileged ring
      ring_r    <= (curRing == 2'h2) ? sap_pkg::RING_USER : curRing;
      user_r    <= userId;
    end
  end

  // Offset is 16 halfwords bits, so a segment can never exceed 128 KB
  assign curSeg = xlateAddr_r[sap_pkg::SEG_LSB +: sap_pkg::SEG_W];

  sap_xlate_buf u_xbuf (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .lkSeg         (curSeg),
    .lkPage        (xlateAddr_r[sap_pkg::PAGE_LSB +: sap_pkg::PAGE_W]),
    .lkUser        (user_r),
    .lkHit         (lkHit),
    .lkPhysPage    (lkPhysPage),
    .lkResident    (lkResident),
    .lkUserPerm    (lkUserPerm),
    .lkMidPerm     (lkMidPerm),
    .lkKernelSeg   (lkKernelSeg),
    .lkGate        (lkGate),
    .fillValid     (fillValid),
    .flushAll      (flushAll),
    .fillSeg       (fillSeg),
    .fillPage      (fillPage),
    .fillUser      (fillUser),
    .fillPhysPage  (fillPhysPage),
    .fillResident  (fillResident),
    .fillUserPerm  (fillUserPerm),
    .fillMidPerm   (fillMidPerm),
    .fillKernelSeg (fillKernelSeg),
    .fillGate      (fillGate)
  );

  // Rights check, same beat the cache address register is presented
  always_comb begin
    unique case (refType_r)
      sap_pkg::REF_WRITE: needBit = 1'b1;
      sap_pkg::REF_FETCH: needBit = 1'b1;
      sap_pkg::REF_READ:  needBit = 1'b1;
      default:            needBit = 1'b0;
    endcase
    if (ring_r == sap_pkg::RING_KERNEL) begin
      allow = 1'b1;
    end else if (lkKernelSeg) begin
      allow = (refType_r == sap_pkg::REF_FETCH) && lkGate;
    end else if (ring_r == sap_pkg::RING_MID) begin
      // Middle ring keeps every user right and adds its own
      allow = ((refType_r == sap_pkg::REF_READ)  &&
               (lkMidPerm[sap_pkg::PERM_READ]  || lkUserPerm[sap_pkg::PERM_READ]))  ||
              ((refType_r == sap_pkg::REF_WRITE) &&
               (lkMidPerm[sap_pkg::PERM_WRITE] || lkUserPerm[sap_pkg::PERM_WRITE])) ||
              ((refType_r == sap_pkg::REF_FETCH) &&
               (lkMidPerm[sap_pkg::PERM_EXEC]  || lkUserPerm[sap_pkg::PERM_EXEC]));
    end else begin
      allow = ((refType_r == sap_pkg::REF_READ)  && lkUserPerm[sap_pkg::PERM_READ])  ||
              ((refType_r == sap_pkg::REF_WRITE) && lkUserPerm[sap_pkg::PERM_WRITE]) ||
              ((refType_r == sap_pkg::REF_FETCH) && lkUserPerm[sap_pkg::PERM_EXEC]);
    end
    allow = allow && needBit;
  end

  // Miss outranks violation, which outranks a page fault: a miss has no rights
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r    <= 1'b0;
      granted_r <= 1'b0;
      trap_r    <= 1'b0;
      cause_r   <= sap_pkg::TRAP_NONE;
      phys_r    <= sap_pkg::PA_RST;
    end else if (state_r == sap_pkg::ST_CHECK) begin
      done_r <= 1'b1;
      phys_r <= {lkPhysPage, xlateAddr_r[sap_pkg::PAGE_LSB-1:0]};
      if (!lkHit) begin
        granted_r <= 1'b0;
        trap_r    <= 1'b1;
        cause_r   <= sap_pkg::TRAP_MISS;
      end else if (!allow) begin
        granted_r <= 1'b0;
        trap_r    <= 1'b1;
        cause_r   <= sap_pkg::TRAP_ACCESS;
      end else if (!lkResident) begin
        granted_r <= 1'b0;
        trap_r    <= 1'b1;
        cause_r   <= sap_pkg::TRAP_PAGE;
      end else begin
        granted_r <= 1'b1;
        trap_r    <= 1'b0;
        cause_r   <= sap_pkg::TRAP_NONE;
      end
    end else begin
      done_r    <= 1'b0;
      granted_r <= 1'b0;
      trap_r    <= 1'b0;
      cause_r   <= sap_pkg::TRAP_NONE;
    end
  end

  // Segment group and sharing decode of the checked reference
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_r  <= '0;
      shared_r <= 1'b0;
    end else if (state_r == sap_pkg::ST_CHECK) begin
      group_r  <= curSeg[sap_pkg::SEG_W-1 -: sap_pkg::SEG_GROUP_W];
      shared_r <= (curSeg < sap_pkg::SHARED_SEGS);
    end
  end

endmodule // sap_top

// ---- core/sap_xlate_buf.sv ----
// Segment translation buffer: small fully associative map of recent pages.
// Lookup is combinational; the caller registers the result. Fill and flush
// come from the translation-miss microcode on the same clock.
`timescale 1ns/10ps
module sap_xlate_buf (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Lookup
  input  wire logic [sap_pkg::SEG_W-1:0]     lkSeg,
  input  wire logic [sap_pkg::PAGE_W-1:0]    lkPage,
  input  wire logic [sap_pkg::USER_W-1:0]    lkUser,
  output logic                               lkHit,
  output logic [sap_pkg::PPN_W-1:0]          lkPhysPage,
  output logic                               lkResident,
  output logic [2:0]                         lkUserPerm,
  output logic [2:0]                         lkMidPerm,
  output logic                               lkKernelSeg,
  output logic                               lkGate,
  // Fill and flush
  input  wire logic                          fillValid,
  input  wire logic                          flushAll,
  input  wire logic [sap_pkg::SEG_W-1:0]     fillSeg,
  input  wire logic [sap_pkg::PAGE_W-1:0]    fillPage,
  input  wire logic [sap_pkg::USER_W-1:0]    fillUser,
  input  wire logic [sap_pkg::PPN_W-1:0]     fillPhysPage,
  input  wire logic                          fillResident,
  input  wire logic [2:0]                    fillUserPerm,
  input  wire logic [2:0]                    fillMidPerm,
  input  wire logic                          fillKernelSeg,
  input  wire logic                          fillGate
);

  localparam int D = sap_pkg::XB_DEPTH;

  logic [D-1:0]                      valid_r;
  logic [sap_pkg::SEG_W-1:0]         seg_r    [D];
  logic [sap_pkg::PAGE_W-1:0]        page_r   [D];
  logic [sap_pkg::USER_W-1:0]        user_r   [D];
  logic [sap_pkg::PPN_W-1:0]         ppn_r    [D];
  logic [D-1:0]                      res_r;
  logic [2:0]                        uPerm_r  [D];
  logic [2:0]                        mPerm_r  [D];
  logic [D-1:0]                      kern_r;
  logic [D-1:0]                      gate_r;
  logic [sap_pkg::XB_IDX_W-1:0]      victim_r;
  logic [D-1:0]                      match;

  // Lower half of segment space is shared, so its entries ignore the user
  genvar gi;
  generate
    for (gi = 0; gi < D; gi++) begin : g_match
      assign match[gi] = valid_r[gi] && (seg_r[gi] == lkSeg) && (page_r[gi] == lkPage) &&
                         ((seg_r[gi] < sap_pkg::SHARED_SEGS) || (user_r[gi] == lkUser));
    end
  endgenerate

  always_comb begin
    lkHit       = 1'b0;
    lkPhysPage  = '0;
    lkResident  = 1'b0;
    lkUserPerm  = 3'h0;
    lkMidPerm   = 3'h0;
    lkKernelSeg = 1'b0;
    lkGate      = 1'b0;
    for (int i = D - 1; i >= 0; i--) begin
      if (match[i]) begin
        lkHit       = 1'b1;
        lkPhysPage  = ppn_r[i];
        lkResident  = res_r[i];
        lkUserPerm  = uPerm_r[i];
        lkMidPerm   = mPerm_r[i];
        lkKernelSeg = kern_r[i];
        lkGate      = gate_r[i];
      end
    end
  end

  // Round-robin replacement; a flush in the same cycle as a fill wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r  <= '0;
      victim_r <= '0;
    end else if (flushAll) begin
      valid_r  <= '0;
    end else if (fillValid) begin
      valid_r[victim_r] <= 1'b1;
      victim_r          <= victim_r + 1'b1;
    end
  end

  // Payload needs no reset: it is only read behind a valid bit
  always_ff @(posedge sys_clk) begin
    if (fillValid) begin
      seg_r[victim_r]   <= fillSeg;
      page_r[victim_r]  <= fillPage;
      user_r[victim_r]  <= fillUser;
      ppn_r[victim_r]   <= fillPhysPage;
      res_r[victim_r]   <= fillResident;
      uPerm_r[victim_r] <= fillUserPerm;
      mPerm_r[victim_r] <= fillMidPerm;
      kern_r[victim_r]  <= fillKernelSeg;
      gate_r[victim_r]  <= fillGate;
    end
  end

endmodule // sap_xlate_buf

// ---- sim/sap_miss_model.sv ----
// Translation-miss microcode model: answers each miss with one fill.
// Assumes no new request follows a miss until the fill has landed.
`timescale 1ns/10ps
module sap_miss_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Watched results
  input  wire logic        refDone,
  input  wire logic        memTrap,
  input  wire logic [1:0]  trapCause,
  input  wire logic [27:0] xlateAddr,
  input  wire logic [7:0]  userId,
  // Table entry for the next fill
  input  wire logic        slowFill,
  input  wire logic        attrRes,
  input  wire logic        attrKer,
  input  wire logic        attrGate,
  input  wire logic [2:0]  attrUser,
  input  wire logic [2:0]  attrMid,
  // Fill port
  output logic             fillValid,
  output logic [11:0]      fillSeg,
  output logic [5:0]       fillPage,
  output logic [7:0]       fillUser,
  output logic [15:0]      fillPhysPage,
  output logic             fillResident,
  output logic [2:0]       fillUserPerm,
  output logic [2:0]       fillMidPerm,
  output logic             fillKernelSeg,
  output logic             fillGate
);
  logic [1:0] waitCnt;

  // Idle fields toggle so a stale entry never looks like a real one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      fillValid <= 1'b0;
      {fillSeg, fillPage, fillUser, fillPhysPage} <= '0;
      {fillResident, fillUserPerm, fillMidPerm, fillKernelSeg, fillGate} <= '0;
    end else if (refDone && memTrap && trapCause == sap_pkg::TRAP_MISS) begin
      waitCnt <= slowFill ? 2'h3 : 2'h1;
      fillSeg <= xlateAddr[27:16];
      fillPage <= xlateAddr[15:10];
      fillUser <= userId;
    end else if (waitCnt == 2'h1) begin
      waitCnt <= 2'h0;
      fillValid <= 1'b1;
      fillPhysPage <= {4'hA, fillSeg[5:0], fillPage};
      fillResident <= attrRes;
      fillUserPerm <= attrUser;
      fillMidPerm <= attrMid;
      {fillKernelSeg, fillGate} <= {attrKer, attrGate};
    end else if (waitCnt != 2'h0) begin
      waitCnt <= waitCnt - 2'h1;
    end else begin
      fillValid <= 1'b0;
      {fillSeg, fillPage, fillUser, fillPhysPage} <= ~{fillSeg, fillPage, fillUser, fillPhysPage};
      {fillResident, fillUserPerm, fillMidPerm} <= ~{fillResident, fillUserPerm, fillMidPerm};
      {fillKernelSeg, fillGate} <= ~{fillKernelSeg, fillGate};
    end
  end
endmodule // sap_miss_model

// ---- sim/sap_top_bench.sv ----
// Self-checking bench for sap_top with the miss microcode model.
// Results are predicted from ring, type and table entry, oldest first.
`timescale 1ns/10ps
module sap_top_bench;
  typedef struct packed {logic g; logic [1:0] c; logic [25:0] pa; logic [2:0] gs;} sap_exp_s;
  localparam logic [4:0] SRCS [3] = '{5'h01, 5'h02, 5'h04};
  localparam logic [2:0] TYPS [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  localparam logic [1:0] RINGS [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  localparam logic [8:0] ATTRS [6] = '{9'h10A, 9'h1FF, 9'h0BF, 9'h038, 9'h131, 9'h104};
  logic        sys_clk, rst_n, refValid, flushAll, slowFill, aRes, aKer, aGate;
  logic        fillValid, fillResident, fillKernelSeg, fillGate;
  logic        refDone, refGranted, memTrap, sharedSeg;
  logic [2:0]  refType, aUp, aMp, fillUserPerm, fillMidPerm;
  logic [1:0]  curRing, trapCause, segGroup;
  logic [4:0]  refSrc;
  logic [7:0]  userId, fillUser;
  logic [11:0] fillSeg;
  logic [5:0]  fillPage;
  logic [15:0] fillPhysPage;
  logic [25:0] physAddr;
  logic [27:0] pcAddr, operandAddr, microAddr, internalAddrBus, cacheAddr, xlateAddr;
  logic [27:0] workingMemAddr, operandBackupAddr, pcBackupAddr, lastPc, lastOp, lastAny;
  logic [27:0] aTab [6];
  sap_exp_s    expQ [$];
  sap_exp_s    e;
  int          num_errors, total_checks, i, j, k;
  integer      seed;

  sap_top i_sap_top (.sys_clk, .rst_n, .pcAddr, .operandAddr, .microAddr, .refValid,
    .refSrc, .refType, .curRing, .userId, .fillValid, .flushAll, .fillSeg, .fillPage,
    .fillUser, .fillPhysPage, .fillResident, .fillUserPerm, .fillMidPerm, .fillKernelSeg,
    .fillGate, .internalAddrBus, .cacheAddr, .xlateAddr, .workingMemAddr,
    .operandBackupAddr, .pcBackupAddr, .refDone, .refGranted, .memTrap, .trapCause,
    .physAddr, .segGroup, .sharedSeg);
  sap_miss_model i_sap_miss_model (.sys_clk, .rst_n, .refDone, .memTrap, .trapCause,
    .xlateAddr, .userId, .slowFill, .attrRes(aRes), .attrKer(aKer), .attrGate(aGate),
    .attrUser(aUp), .attrMid(aMp), .fillValid, .fillSeg, .fillPage, .fillUser,
    .fillPhysPage, .fillResident, .fillUserPerm, .fillMidPerm, .fillKernelSeg, .fillGate);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string n, input logic [27:0] seen, input logic [27:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Miss outranks access violation, which outranks page fault
  function automatic sap_exp_s predict(input logic [27:0] a, input logic [2:0] t,
                                       input logic [1:0] r, input logic hit);
    sap_exp_s   p;
    logic [2:0] eff;
    eff = (r == 2'h0) ? 3'h7 : (r == 2'h1) ? (aUp | aMp) : aUp;
    if (aKer && r != 2'h0) eff = aGate ? 3'h4 : 3'h0;
    p.c = !hit ? 2'h1 : !($onehot(t) && (t & eff) != 3'h0) ? 2'h2 : aRes ? 2'h0 : 2'h3;
    p.g = p.c == 2'h0;
    p.pa = {4'hA, a[21:0]};
    p.gs = {a[27:26], !a[27]};
    return p;
  endfunction

  task automatic issue(input logic [4:0] s, input logic [2:0] t, input logic [1:0] r,
                       input logic [7:0] u, input logic [27:0] a, input logic hit);
    @(posedge sys_clk);
    refValid <= 1'b1;
    {refSrc, refType, curRing, userId} <= {s, t, r, u};
    pcAddr <= (s == 5'h01) ? a : 28'($random(seed));
    operandAddr <= (s == 5'h02) ? a : 28'($random(seed));
    microAddr <= (s == 5'h04) ? a : 28'($random(seed));
    if ($onehot(s)) expQ.push_back(predict(a, t, r, hit));
    if ($onehot(s)) lastAny = a;
    if (s == 5'h01) lastPc = a;
    if (s == 5'h02) lastOp = a;
  endtask

  // Waits for every predicted result, then for the model's fill
  task automatic drain();
    @(posedge sys_clk);
    refValid <= 1'b0;
    for (i = 0; i < 20 && expQ.size() != 0; i++) @(posedge sys_clk);
    if (expQ.size() != 0) begin
      num_errors++;
      conclude();
    end
    repeat (6) @(posedge sys_clk);
  endtask

  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && refDone !== 1'b0) begin
      if (expQ.size() == 0) check("unrequested result", 28'h1, 28'h0);
      else begin
        e = expQ.pop_front();
        check("refGranted", 28'(refGranted), 28'(e.g));
        check("trapCause", 28'(trapCause), 28'(e.c));
        check("segGroup sharedSeg", 28'({segGroup, sharedSeg}), 28'(e.gs));
        if (e.g) check("physAddr", 28'(physAddr), 28'(e.pa));
      end
    end
  end

  initial begin
    seed = 32'h69BE;
    {refValid, flushAll, slowFill, refSrc, refType, curRing, userId} = '0;
    {pcAddr, operandAddr, microAddr, aRes, aKer, aGate, aUp, aMp} = '0;
    num_errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 6; k++) begin
      {aRes, aKer, aGate, aUp, aMp} <= ATTRS[k];
      slowFill <= k[0];
      aTab[k] = {2'(k), 4'(k), 6'h25, 16'($random(seed))};
      issue(5'h01, 3'h4, 2'h3, 8'h11, aTab[k], 1'b0);
      drain();
      for (j = 0; j < 16; j++) begin
        issue(SRCS[j % 3], TYPS[j % 4], RINGS[j / 4], 8'h11,
              {aTab[k][27:10], 10'($random(seed))}, 1'b1);
      end
      drain();
      check("pcBackupAddr", pcBackupAddr, lastPc);
      check("operandBackupAddr", operandBackupAddr, lastOp);
      check("cacheAddr", cacheAddr, lastPc);
    end
    issue(5'h08, 3'h1, 2'h0, 8'h22, lastOp, 1'b1);
    issue(5'h04, 3'h1, 2'h0, 8'h22, aTab[2], 1'b0);
    drain();
    issue(5'h03, 3'h1, 2'h0, 8'h11, aTab[0], 1'b1);
    drain();
    check("internalAddrBus", internalAddrBus, lastAny);
    @(posedge sys_clk);
    flushAll <= 1'b1;
    @(posedge sys_clk);
    flushAll <= 1'b0;
    issue(5'h10, 3'h4, 2'h0, 8'h11, lastPc, 1'b0);
    drain();
    conclude();
  end
endmodule // sap_top_bench

// ---- sim/sap_top_chk.sv ----
// Port-level checker for sap_top, bound onto every instance.
// Assumes results land two edges after an accepted request.
`timescale 1ns/10ps
module sap_top_chk (
  // Clock and reset
  input wire logic                             sys_clk,
  input wire logic                             rst_n,
  // Request side
  input wire logic [sap_pkg::VA_W-1:0]         pcAddr,
  input wire logic [sap_pkg::VA_W-1:0]         operandAddr,
  input wire logic                             refValid,
  input wire logic [4:0]                       refSrc,
  input wire logic [2:0]                       refType,
  input wire logic [1:0]                       curRing,
  // Address registers
  input wire logic [sap_pkg::VA_W-1:0]         internalAddrBus,
  input wire logic [sap_pkg::VA_W-1:0]         cacheAddr,
  input wire logic [sap_pkg::VA_W-1:0]         xlateAddr,
  input wire logic [sap_pkg::VA_W-1:0]         workingMemAddr,
  input wire logic [sap_pkg::VA_W-1:0]         operandBackupAddr,
  input wire logic [sap_pkg::VA_W-1:0]         pcBackupAddr,
  // Check result
  input wire logic                             refDone,
  input wire logic                             refGranted,
  input wire logic                             memTrap,
  input wire logic [1:0]                       trapCause,
  input wire logic [sap_pkg::PA_W-1:0]         physAddr,
  input wire logic [sap_pkg::SEG_GROUP_W-1:0]  segGroup,
  input wire logic                             sharedSeg
);
  logic accepted;
  assign accepted = refValid && $onehot(refSrc);

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence op_load;
    refValid && refSrc == sap_pkg::SRC_OPERAND;
  endsequence
  sequence pc_load;
    refValid && refSrc == sap_pkg::SRC_PC;
  endsequence

  bus_fanout_a: assert property (accepted |=> cacheAddr == internalAddrBus
    && xlateAddr == internalAddrBus && workingMemAddr == internalAddrBus)
    else $error("address register differs from bus");
  pc_path_a: assert property (pc_load |=> internalAddrBus == $past(pcAddr))
    else $error("bus missed program counter");
  op_load_a: assert property (op_load |=> operandBackupAddr == $past(operandAddr))
    else $error("operand backup not loaded");
  op_hold_a: assert property (!refValid || refSrc != 5'h02 |=> $stable(operandBackupAddr))
    else $error("operand backup changed");
  pc_load_a: assert property (pc_load |=> pcBackupAddr == $past(pcAddr))
    else $error("pc backup not loaded");
  pc_hold_a: assert property (!refValid || refSrc != 5'h01 |=> $stable(pcBackupAddr))
    else $error("pc backup changed");
  done_time_a: assert property (accepted |-> ##2 refDone)
    else $error("missing result beat");
  done_cause_a: assert property (refDone |-> $past(accepted, 2))
    else $error("result without request");
  grant_excl_a: assert property ((refDone || refGranted || memTrap)
    |-> refDone && refGranted != memTrap) else $error("grant and trap clash");
  cause_code_a: assert property (refDone |-> refGranted == (trapCause == 2'h0))
    else $error("trap cause wrong");
  share_split_a: assert property (refDone |-> sharedSeg == !$past(internalAddrBus[27]))
    else $error("shared flag wrong");
  group_dec_a: assert property (refDone |-> segGroup == $past(internalAddrBus[27:26]))
    else $error("segment group wrong");
  offset_pass_a: assert property (refGranted |-> physAddr[9:0] == $past(internalAddrBus[9:0]))
    else $error("offset bits altered");
  kernel_all_a: assert property (refDone && $past(curRing, 2) == 2'h0
    && $onehot($past(refType, 2)) |-> trapCause != 2'h2) else $error("kernel refused");
endmodule // sap_top_chk

bind sap_top sap_top_chk i_sap_top_chk (
  .sys_clk, .rst_n, .pcAddr, .operandAddr, .refValid, .refSrc, .refType, .curRing,
  .internalAddrBus, .cacheAddr, .xlateAddr, .workingMemAddr, .operandBackupAddr,
  .pcBackupAddr, .refDone, .refGranted, .memTrap, .trapCause, .physAddr, .segGroup,
  .sharedSeg
);
